// >>> dv/itpc_power_control_bench.sv
`timescale 1ns/1ns
`include "itpc_regs.vh"
module itpc_power_control_bench;
   reg pclk, presetn, psel, penable, pwrite, sense_valid, send_err, send_end, e;
   reg [11:0] paddr;
   reg [31:0] pwdata, q;
   reg [15:0] sense_current_ma;
   reg [7:0] reply, err_in;
   wire [31:0] prdata;
   wire pready, pslverr, strength_valid, error_valid, end_valid, power_enable;
   wire [7:0] strength_value, error_value;
   wire [16:0] freq;
   wire [13:0] supply_mv;
   integer n_errors, total_checks, cyc, i;
   itpc_power_control #(.PING_WAIT_US(5), .OFF_WAIT_US(2)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sense_valid(sense_valid), .sense_current_ma(sense_current_ma),
      .strength_valid(strength_valid), .strength_value(strength_value), .error_valid(error_valid),
      .error_value(error_value), .end_valid(end_valid), .power_enable(power_enable),
      .inverter_operating_frequency(freq), .supply_mv(supply_mv));
   itpc_rx_model u_rx (.pclk(pclk), .presetn(presetn), .power_enable(power_enable), .reply(reply),
      .delay(8'h0a), .send_err(send_err), .err_in(err_in), .send_end(send_end),
      .strength_valid(strength_valid), .strength_value(strength_value), .error_valid(error_valid),
      .error_value(error_value), .end_valid(end_valid));
   task end_sim;
      begin
         $display("checks %0d errors %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] x);
      begin
         total_checks = total_checks + 1;
         if (g !== x)
         begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         @(posedge pclk);
         while (pready !== 1'h1)
            @(posedge pclk);
         q = prdata;
         e = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge pclk);
      end
   endtask
   task wait_pe(input v);
      integer n;
      begin
         n = 0;
         while (power_enable !== v && n < 400)
         begin
            n = n + 1;
            @(posedge pclk);
         end
         chk(power_enable, v);
      end
   endtask
   task sense(input [15:0] v, input [16:0] f, input [13:0] mv);
      begin
         sense_current_ma <= v;
         sense_valid <= 1'h1;
         @(posedge pclk);
         sense_valid <= 1'h0;
         sense_current_ma <= ~v;
         repeat (2) @(posedge pclk);
         chk(freq, f);
         chk(supply_mv, mv);
      end
   endtask
   task err_pkt(input [7:0] v);
      begin
         send_err <= 1'h1;
         err_in <= v;
         @(posedge pclk);
         send_err <= 1'h0;
         @(posedge pclk);
      end
   endtask
   task t_reset;
      begin
         chk(freq, `ITPC_PING_FREQ);
         chk(supply_mv, `ITPC_PING_VOLT);
         chk(power_enable, 1'h0);
         apb(1'h0, `ITPC_PING_CFG_OFFSET, 32'h0);
         chk(q, 32'h07d00501);
         apb(1'h0, 12'h018, 32'h0);
         chk(q, 32'h0);
         chk(e, 1'h1);
         $display("t_reset done");
      end
   endtask
   task t_fail;
      begin
         reply <= 8'h00;
         apb(1'h1, `ITPC_CTRL_OFFSET, 32'h1);
         for (i = 0; i < 6; i = i + 1)
         begin
            wait_pe(1'h1);
            chk(freq, `ITPC_PING_FREQ - 17'h007d0 * i);
            chk(supply_mv, `ITPC_PING_VOLT);
            wait_pe(1'h0);
         end
         repeat (100) @(posedge pclk);
         chk(power_enable, 1'h0);
         apb(1'h0, `ITPC_STATUS_OFFSET, 32'h0);
         chk({q[16], q[2:0]}, 4'hc);
         apb(1'h1, `ITPC_CTRL_OFFSET, 32'h0);
         $display("t_fail done");
      end
   endtask
   task t_regulate;
      begin
         reply <= 8'h05;
         apb(1'h1, `ITPC_PING_CFG_OFFSET, 32'h07d0050a);
         apb(1'h1, `ITPC_CTRL_OFFSET, 32'h1);
         wait_pe(1'h1);
         sense(16'h03e8, `ITPC_PING_FREQ, `ITPC_PING_VOLT);
         wait_pe(1'h0);
         reply <= 8'h14;
         wait_pe(1'h1);
         chk(freq, 17'h17700);
         repeat (30) @(posedge pclk);
         apb(1'h0, `ITPC_STATUS_OFFSET, 32'h0);
         chk(q[2:0], 3'h3);
         err_pkt(8'h40);
         apb(1'h0, `ITPC_CURRENT_OFFSET, 32'h0);
         chk(q[31:16], 16'h05dc);
         sense(16'h044c, 17'h17570, `ITPC_PING_VOLT);
         sense(16'h7530, `ITPC_FREQ_MAX, 14'h128e);
         sense(16'h7530, `ITPC_FREQ_MAX, 14'h0fa0);
         sense(16'h05dc, `ITPC_FREQ_MAX, 14'h0fa0);
         sense(16'h01f4, 17'h1a9c8, 14'h0fa0);
         sense(16'h7530, `ITPC_FREQ_MAX, 14'h0cb2);
         err_pkt(8'h7f);
         apb(1'h0, `ITPC_CURRENT_OFFSET, 32'h0);
         chk(q, 32'he9757530);
         sense(16'h0000, 17'h15f90, 14'h0cb2);
         sense(16'h0000, `ITPC_FREQ_MIN, 14'h0fa0);
         $display("t_regulate done");
      end
   endtask
   task t_end;
      begin
         send_end <= 1'h1;
         @(posedge pclk);
         send_end <= 1'h0;
         wait_pe(1'h0);
         wait_pe(1'h1);
         chk({freq, supply_mv}, {`ITPC_PING_FREQ, `ITPC_PING_VOLT});
         apb(1'h1, `ITPC_CTRL_OFFSET, 32'h0);
         @(posedge pclk);
         chk(power_enable, 1'h0);
         $display("t_end done");
      end
   endtask
   initial
   begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         end_sim;
      end
   end
   initial
   begin
      n_errors = 0;
      total_checks = 0;
      cyc = 0;
      {presetn, psel, penable, pwrite, sense_valid, send_err, send_end} = 7'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      sense_current_ma = 16'h0;
      reply = 8'h0;
      err_in = 8'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_reset;
      t_fail;
      t_regulate;
      t_end;
      end_sim;
   end
endmodule

// >>> dv/itpc_props.sv
`timescale 1ns/1ns
`include "itpc_regs.vh"
module itpc_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire sense_valid,
   input wire power_enable,
   input wire [16:0] inverter_operating_frequency,
   input wire [13:0] supply_mv
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_freq_in_band: assert property (power_enable |-> inverter_operating_frequency >= `ITPC_FREQ_MIN &&
      inverter_operating_frequency <= `ITPC_FREQ_MAX) else $error("frequency out of band");
   a_volt_in_span: assert property (supply_mv >= `ITPC_VOLT_MIN && supply_mv <= `ITPC_VOLT_MAX)
      else $error("supply out of span");
   a_ping_start_freq: assert property ($rose(power_enable) |-> inverter_operating_frequency <= `ITPC_PING_FREQ)
      else $error("ping above start frequency");
   a_freq_step_limit: assert property (power_enable && $past(power_enable) && $changed(inverter_operating_frequency)
      |-> inverter_operating_frequency + 32'd20000 >= $past(inverter_operating_frequency) &&
      $past(inverter_operating_frequency) + 32'd20000 >= inverter_operating_frequency) else $error("freq step");
   a_volt_at_edge: assert property (power_enable && $past(power_enable) && $changed(supply_mv)
      |-> inverter_operating_frequency == `ITPC_FREQ_MIN || inverter_operating_frequency == `ITPC_FREQ_MAX)
      else $error("supply moved off band edge");
   a_volt_step_limit: assert property (power_enable && $past(power_enable) && $changed(supply_mv)
      |-> supply_mv + 32'd750 >= $past(supply_mv) && $past(supply_mv) + 32'd750 >= supply_mv)
      else $error("supply step");
   a_loop_on_sample: assert property (power_enable && $past(power_enable) && $changed(inverter_operating_frequency)
      |-> $past(sense_valid) || $past(sense_valid, 2)) else $error("freq moved without sample");
   a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready timing");
   a_slverr_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
endmodule
bind itpc_power_control itpc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .sense_valid(sense_valid), .power_enable(power_enable),
   .inverter_operating_frequency(inverter_operating_frequency), .supply_mv(supply_mv));

// >>> dv/itpc_rx_model.sv
`timescale 1ns/1ns
module itpc_rx_model (
   input wire pclk,
   input wire presetn,
   input wire power_enable,
   input wire [7:0] reply,
   input wire [7:0] delay,
   input wire send_err,
   input wire [7:0] err_in,
   input wire send_end,
   output reg strength_valid,
   output reg [7:0] strength_value,
   output reg error_valid,
   output reg [7:0] error_value,
   output reg end_valid
);
   reg [7:0] cnt;
   reg was_on;
   // Idle data lines show the inverse of their last value; a reply of zero means silence.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 8'h00;
         was_on <= 1'h0;
         strength_valid <= 1'h0;
         strength_value <= 8'h00;
         error_valid <= 1'h0;
         error_value <= 8'h00;
         end_valid <= 1'h0;
      end
      else
      begin
         was_on <= power_enable;
         error_valid <= send_err;
         end_valid <= send_end;
         error_value <= send_err ? err_in : ~error_value;
         strength_valid <= 1'h0;
         strength_value <= ~strength_value;
         if (power_enable && !was_on)
            cnt <= delay;
         else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
         if (power_enable && cnt == 8'h01 && reply != 8'h00)
         begin
            strength_valid <= 1'h1;
            strength_value <= reply;
         end
      end
   end
endmodule

// >>> rtl/itpc_power_control.v
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "itpc_regs.vh"
module itpc_power_control #(
   parameter PING_WAIT_US = `ITPC_PING_WAIT_US,
   parameter OFF_WAIT_US = `ITPC_OFF_WAIT_US
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire sense_valid,
   input wire [15:0] sense_current_ma,
   input wire strength_valid,
   input wire [7:0] strength_value,
   input wire error_valid,
   input wire [7:0] error_value,
   input wire end_valid,
   output reg power_enable,
   output reg [16:0] inverter_operating_frequency,
   output reg [13:0] supply_mv
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_PING = 3'h1;
   localparam [2:0] ST_OFF = 3'h2;
   localparam [2:0] ST_POWER = 3'h3;
   localparam [2:0] ST_HALT = 3'h4;

   // The wait counter is 24 bits wide, so a window longer than that needs a wider wait_cnt.
   localparam [31:0] PING_CYC_FULL = PING_WAIT_US * `ITPC_CLK_MHZ;
   localparam [31:0] OFF_CYC_FULL = OFF_WAIT_US * `ITPC_CLK_MHZ;
   localparam [23:0] PING_CYC = PING_CYC_FULL[23:0];
   localparam [23:0] OFF_CYC = OFF_CYC_FULL[23:0];

   localparam signed [17:0] FLIM = `ITPC_FREQ_LOOP_LIMIT;
   localparam signed [19:0] VLIM = `ITPC_VOLT_LOOP_LIMIT;
   localparam signed [19:0] FMAX20 = {3'h0, `ITPC_FREQ_MAX};
   localparam signed [19:0] FMIN20 = {3'h0, `ITPC_FREQ_MIN};
   localparam signed [19:0] VMAX20 = {6'h00, `ITPC_VOLT_MAX};
   localparam signed [19:0] VMIN20 = {6'h00, `ITPC_VOLT_MIN};

   reg enable;
   reg [7:0] threshold;
   reg [7:0] max_retries;
   reg [15:0] freq_step;
   reg [2:0] state;
   reg [23:0] wait_cnt;
   reg [7:0] retry_cnt;
   reg exhausted;
   reg [16:0] ping_freq;
   reg [15:0] target_ma;
   reg [15:0] last_ma;

   reg signed [17:0] err;
   reg signed [17:0] pid;
   reg signed [19:0] f_try;
   reg [16:0] next_freq;
   reg signed [19:0] rem;
   reg signed [19:0] vpid;
   reg signed [19:0] v_try;
   reg [13:0] next_volt;
   reg signed [24:0] prod;
   reg signed [25:0] t_sum;
   reg [15:0] next_target;
   reg signed [19:0] retry_try;
   reg retry_ok;

   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pready & pwrite & ~pslverr;

   // APB slave: decode in the setup cycle, answer in the first access cycle.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= setup;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (setup)
         begin
            if (paddr == `ITPC_CTRL_OFFSET)
            begin
               prdata <= {31'h00000000, enable};
            end
            else if (paddr == `ITPC_PING_CFG_OFFSET)
            begin
               prdata <= {freq_step, max_retries, threshold};
            end
            else if (paddr == `ITPC_STATUS_OFFSET)
            begin
               prdata <= {15'h0000, exhausted, retry_cnt, 4'h0, power_enable, state};
            end
            else if (paddr == `ITPC_FREQ_OFFSET)
            begin
               prdata <= {15'h0000, inverter_operating_frequency};
            end
            else if (paddr == `ITPC_VOLT_OFFSET)
            begin
               prdata <= {18'h00000, supply_mv};
            end
            else if (paddr == `ITPC_CURRENT_OFFSET)
            begin
               prdata <= {target_ma, last_ma};
            end
            else
            begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enable <= `ITPC_CTRL_RESET;
         threshold <= `ITPC_THRESHOLD_RESET;
         max_retries <= `ITPC_RETRIES_RESET;
         freq_step <= `ITPC_STEP_RESET;
      end
      else if (wr_en)
      begin
         if (paddr == `ITPC_CTRL_OFFSET)
         begin
            enable <= pwdata[`ITPC_CTRL_ENABLE_BIT];
         end
         else if (paddr == `ITPC_PING_CFG_OFFSET)
         begin
            threshold <= pwdata[`ITPC_THRESHOLD_LSB +: 8];
            max_retries <= pwdata[`ITPC_RETRIES_LSB +: 8];
            freq_step <= pwdata[`ITPC_STEP_LSB +: 16];
         end
      end
   end

   // One proportional step of both loops for the newest current sample.
   always @*
   begin
      err = $signed({2'b00, target_ma}) - $signed({2'b00, sense_current_ma});
      if (err > FLIM)
      begin
         pid = FLIM;
      end
      else if (err < -FLIM)
      begin
         pid = -FLIM;
      end
      else
      begin
         pid = err;
      end
      f_try = $signed({3'h0, inverter_operating_frequency}) - {{2{pid[17]}}, pid};
      if (f_try > FMAX20)
      begin
         next_freq = `ITPC_FREQ_MAX;
      end
      else if (f_try < FMIN20)
      begin
         next_freq = `ITPC_FREQ_MIN;
      end
      else
      begin
         next_freq = f_try[16:0];
      end
      // Nonzero only when the frequency hit a band edge.
      rem = $signed({3'h0, next_freq}) - f_try;
      if (rem > VLIM)
      begin
         vpid = VLIM;
      end
      else if (rem < -VLIM)
      begin
         vpid = -VLIM;
      end
      else
      begin
         vpid = rem;
      end
      v_try = $signed({6'h00, supply_mv}) + (vpid >>> 1);
      if (v_try > VMAX20)
      begin
         next_volt = `ITPC_VOLT_MAX;
      end
      else if (v_try < VMIN20)
      begin
         next_volt = `ITPC_VOLT_MIN;
      end
      else
      begin
         next_volt = v_try[13:0];
      end
      prod = $signed({1'b0, last_ma}) * $signed(error_value);
      t_sum = $signed({10'h000, last_ma}) + ($signed({prod[24], prod}) >>> 7);
      if (t_sum < 26'sd0)
      begin
         next_target = 16'h0000;
      end
      else if (t_sum > $signed({10'h000, 16'hffff}))
      begin
         next_target = 16'hffff;
      end
      else
      begin
         next_target = t_sum[15:0];
      end
      retry_try = $signed({3'h0, ping_freq}) - $signed({4'h0, freq_step});
      retry_ok = (retry_try >= FMIN20) && (retry_cnt < max_retries) && (freq_step != 16'h0000);
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         wait_cnt <= 24'h000000;
         retry_cnt <= 8'h00;
         exhausted <= 1'b0;
         ping_freq <= `ITPC_PING_FREQ;
         target_ma <= 16'h0000;
         last_ma <= 16'h0000;
         power_enable <= 1'b0;
         inverter_operating_frequency <= `ITPC_PING_FREQ;
         supply_mv <= `ITPC_PING_VOLT;
      end
      else
      begin
         if (sense_valid)
         begin
            last_ma <= sense_current_ma;
         end
         if (!enable)
         begin
            state <= ST_IDLE;
            power_enable <= 1'b0;
            exhausted <= 1'b0;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  retry_cnt <= 8'h00;
                  ping_freq <= `ITPC_PING_FREQ;
                  inverter_operating_frequency <= `ITPC_PING_FREQ;
                  supply_mv <= `ITPC_PING_VOLT;
                  power_enable <= 1'b1;
                  wait_cnt <= PING_CYC - 24'h000001;
                  state <= ST_PING;
               end
               ST_PING:
               begin
                  if (strength_valid && (strength_value >= threshold))
                  begin
                     target_ma <= last_ma;
                     state <= ST_POWER;
                  end
                  else if (wait_cnt == 24'h000000)
                  begin
                     power_enable <= 1'b0;
                     wait_cnt <= OFF_CYC - 24'h000001;
                     if (retry_ok)
                     begin
                        ping_freq <= retry_try[16:0];
                        retry_cnt <= retry_cnt + 8'h01;
                        state <= ST_OFF;
                     end
                     else
                     begin
                        exhausted <= 1'b1;
                        state <= ST_HALT;
                     end
                  end
                  else
                  begin
                     wait_cnt <= wait_cnt - 24'h000001;
                  end
               end
               ST_OFF:
               begin
                  if (wait_cnt == 24'h000000)
                  begin
                     inverter_operating_frequency <= ping_freq;
                     supply_mv <= `ITPC_PING_VOLT;
                     power_enable <= 1'b1;
                     wait_cnt <= PING_CYC - 24'h000001;
                     state <= ST_PING;
                  end
                  else
                  begin
                     wait_cnt <= wait_cnt - 24'h000001;
                  end
               end
               ST_POWER:
               begin
                  if (end_valid)
                  begin
                     power_enable <= 1'b0;
                     retry_cnt <= 8'h00;
                     ping_freq <= `ITPC_PING_FREQ;
                     wait_cnt <= OFF_CYC - 24'h000001;
                     state <= ST_OFF;
                  end
                  else
                  begin
                     if (error_valid)
                     begin
                        target_ma <= next_target;
                     end
                     if (sense_valid)
                     begin
                        inverter_operating_frequency <= next_freq;
                        supply_mv <= next_volt;
                     end
                  end
               end
               ST_HALT:
               begin
                  power_enable <= 1'b0;
               end
               default:
               begin
                  state <= ST_IDLE;
                  power_enable <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

// >>> rtl/itpc_regs.vh
`ifndef ITPC_REGS_VH
`define ITPC_REGS_VH

`define ITPC_CTRL_OFFSET 12'h000
`define ITPC_PING_CFG_OFFSET 12'h004
`define ITPC_STATUS_OFFSET 12'h008
`define ITPC_FREQ_OFFSET 12'h00c
`define ITPC_VOLT_OFFSET 12'h010
`define ITPC_CURRENT_OFFSET 12'h014

`define ITPC_CTRL_ENABLE_BIT 0
`define ITPC_CTRL_RESET 1'b0
`define ITPC_THRESHOLD_LSB 0
`define ITPC_RETRIES_LSB 8
`define ITPC_STEP_LSB 16
`define ITPC_THRESHOLD_RESET 8'h01
`define ITPC_RETRIES_RESET 8'h05
`define ITPC_STEP_RESET 16'h07d0

`define ITPC_FREQ_MIN 17'h153d8
`define ITPC_FREQ_MAX 17'h1adb0
`define ITPC_PING_FREQ 17'h17ed0
`define ITPC_VOLT_MIN 14'h09c4
`define ITPC_VOLT_MAX 14'h2cec
`define ITPC_PING_VOLT 14'h157c
`define ITPC_FREQ_LOOP_LIMIT 18'h04e20
`define ITPC_VOLT_LOOP_LIMIT 20'h005dc

`define ITPC_CLK_MHZ 10
`define ITPC_PING_WAIT_US 20000
`define ITPC_OFF_WAIT_US 5000

`endif
